// ---- src/cwtr_pkg.sv ----
package cwtr_pkg;

	// ---------------------------------------------------------------
	// register map and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_HF_UNDER = 8'h50;
	localparam logic [7:0] ADDR_HF_OVER = 8'h51;
	localparam logic [7:0] ADDR_LF_UNDER = 8'h52;
	localparam logic [7:0] ADDR_LF_OVER = 8'h53;
	localparam logic [7:0] RST_UNDER_LIMIT = 8'h00;
	localparam logic [7:0] RST_OVER_LIMIT = 8'hff;
	// over limits reset to all ones, so their voltage starts at the unity-scale ceiling, not the floor
	localparam logic [12:0] RST_OVER_MV = 13'h05c3;

	// ---------------------------------------------------------------
	// code to voltage scaling, in millivolts
	// ---------------------------------------------------------------
	localparam int MV_WIDTH = 13;
	localparam logic [12:0] SCALE1_FLOOR_MV = 13'h00c8;
	localparam logic [12:0] SCALE1_STEP_MV = 13'h0005;
	localparam logic [12:0] SCALE4_FLOOR_MV = 13'h0320;
	localparam logic [12:0] SCALE4_STEP_MV = 13'h0014;

	// ---------------------------------------------------------------
	// settle timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int SETTLE_BASE_NS = 100;
	localparam int SETTLE_MAX_CODE = 10;
	localparam int SETTLE_CNT_WIDTH = 12;
	localparam logic [11:0] SETTLE_CNT_ZERO = 12'h000;

	typedef struct packed {
		logic [7:0] hf_under;
		logic [7:0] hf_over;
		logic [7:0] lf_under;
		logic [7:0] lf_over;
	} cwtr_limits_t;

	typedef struct packed {
		logic [12:0] hf_under;
		logic [12:0] hf_over;
		logic [12:0] lf_under;
		logic [12:0] lf_over;
	} cwtr_limits_mv_t;

	typedef struct packed {
		logic hf_under;
		logic hf_over;
		logic lf_under;
		logic lf_over;
	} cwtr_faults_t;

	// least settle time rounds up to whole clock cycles; codes above the cap hold the longest time
	function automatic logic [11:0] cwtr_settle_cycles(input logic [3:0] code);
		int n;
		int c;
		n = (int'(code) > SETTLE_MAX_CODE) ? SETTLE_MAX_CODE : int'(code);
		c = ((SETTLE_BASE_NS << n) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return c[11:0];
	endfunction : cwtr_settle_cycles

	function automatic logic [12:0] cwtr_code_to_mv(input logic [7:0] code, input logic scale4);
		logic [12:0] c13;
		c13 = {5'h00, code};
		if (scale4) begin
			return 13'(SCALE4_FLOOR_MV + c13 * SCALE4_STEP_MV);
		end
		return 13'(SCALE1_FLOOR_MV + c13 * SCALE1_STEP_MV);
	endfunction : cwtr_code_to_mv

endpackage : cwtr_pkg

// ---- src/cwtr_regs.sv ----
// Summary of operation
// - a read/write fast-path low limit sits at 0x50 and clears to 0x00 on reset.
// - a read/write fast-path high limit sits at 0x51 and sets to 0xff on reset.
// - a read/write slow-path low limit sits at 0x52 and clears to 0x00 on reset.
// - a read/write slow-path high limit sits at 0x53 and sets to 0xff on reset.
// - each limit code is turned into a voltage through the range scale select.
// - at unity scale a code means 200 mV plus 5 mV per step, up to 1475 mV.
// - at fourfold scale a code means 800 mV plus 20 mV per step, up to 5900 mV.
// - a fast-path fault is only reported once the comparison has held for its settle time.
`timescale 1ns/1ps
module cwtr_regs (
	input wire logic clock, // 25 MHz
	input wire logic resetn, // async, active low
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic reg_wr, // write strobe, one cycle
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_rd, // read strobe, one cycle
	output logic [7:0] reg_rdata, // read data, zero if unmapped
	output logic reg_rvalid, // read data valid pulse
	input wire logic range_scale_select, // 0 unity, 1 fourfold
	input wire logic [3:0] high_fault_settle_time, // fast-path overvoltage settle code
	input wire logic [3:0] low_fault_settle_time, // fast-path undervoltage settle code
	input wire logic [12:0] hf_sample_mv, // fast-path measured value, mV
	input wire logic [12:0] lf_sample_mv, // slow-path measured value, mV
	output cwtr_pkg::cwtr_limits_t limits, // raw limit codes
	output cwtr_pkg::cwtr_limits_mv_t limits_mv, // limits in mV
	output cwtr_pkg::cwtr_faults_t faults // reported faults
);

	// ---------------------------------------------------------------
	// register file
	// ---------------------------------------------------------------
	cwtr_pkg::cwtr_limits_t limits_reg, limits_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;

	always_comb begin
		limits_next = limits_reg;
		if (reg_wr) begin
			case (reg_addr)
				cwtr_pkg::ADDR_HF_UNDER: limits_next.hf_under = reg_wdata;
				cwtr_pkg::ADDR_HF_OVER: limits_next.hf_over = reg_wdata;
				cwtr_pkg::ADDR_LF_UNDER: limits_next.lf_under = reg_wdata;
				cwtr_pkg::ADDR_LF_OVER: limits_next.lf_over = reg_wdata;
				default: limits_next = limits_reg;
			endcase
		end
		rvalid_next = reg_rd;
		rdata_next = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				cwtr_pkg::ADDR_HF_UNDER: rdata_next = limits_reg.hf_under;
				cwtr_pkg::ADDR_HF_OVER: rdata_next = limits_reg.hf_over;
				cwtr_pkg::ADDR_LF_UNDER: rdata_next = limits_reg.lf_under;
				cwtr_pkg::ADDR_LF_OVER: rdata_next = limits_reg.lf_over;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			limits_reg.hf_under <= cwtr_pkg::RST_UNDER_LIMIT;
			limits_reg.hf_over <= cwtr_pkg::RST_OVER_LIMIT;
			limits_reg.lf_under <= cwtr_pkg::RST_UNDER_LIMIT;
			limits_reg.lf_over <= cwtr_pkg::RST_OVER_LIMIT;
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			limits_reg <= limits_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign limits = limits_reg;
	assign reg_rdata = rdata_reg;
	assign reg_rvalid = rvalid_reg;

	// ---------------------------------------------------------------
	// limit codes to millivolts
	// ---------------------------------------------------------------
	// registered so the comparators see a clean value, at the cost of one cycle after a write
	cwtr_pkg::cwtr_limits_mv_t mv_reg, mv_next;

	always_comb begin
		mv_next.hf_under = cwtr_pkg::cwtr_code_to_mv(limits_reg.hf_under, range_scale_select);
		mv_next.hf_over = cwtr_pkg::cwtr_code_to_mv(limits_reg.hf_over, range_scale_select);
		mv_next.lf_under = cwtr_pkg::cwtr_code_to_mv(limits_reg.lf_under, range_scale_select);
		mv_next.lf_over = cwtr_pkg::cwtr_code_to_mv(limits_reg.lf_over, range_scale_select);
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			// unity-scale reset values; a fourfold select held through reset is only seen one cycle later
			mv_reg.hf_under <= cwtr_pkg::SCALE1_FLOOR_MV;
			mv_reg.hf_over <= cwtr_pkg::RST_OVER_MV;
			mv_reg.lf_under <= cwtr_pkg::SCALE1_FLOOR_MV;
			mv_reg.lf_over <= cwtr_pkg::RST_OVER_MV;
		end else begin
			mv_reg <= mv_next;
		end
	end

	assign limits_mv = mv_reg;

	// ---------------------------------------------------------------
	// comparators and fast-path settle filters
	// ---------------------------------------------------------------
	// index 0 is fast-path undervoltage, index 1 is fast-path overvoltage
	logic [1:0] hf_raw;
	logic [11:0] settle_target [2];
	logic [11:0] cnt_reg [2];
	logic [11:0] cnt_next [2];
	logic [1:0] hf_fault_reg, hf_fault_next;
	logic [1:0] lf_fault_reg, lf_fault_next;

	assign hf_raw[0] = hf_sample_mv < mv_reg.hf_under;
	assign hf_raw[1] = hf_sample_mv > mv_reg.hf_over;
	assign settle_target[0] = cwtr_pkg::cwtr_settle_cycles(low_fault_settle_time);
	assign settle_target[1] = cwtr_pkg::cwtr_settle_cycles(high_fault_settle_time);

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_settle
			always_comb begin
				cnt_next[gi] = cwtr_pkg::SETTLE_CNT_ZERO;
				hf_fault_next[gi] = hf_fault_reg[gi];
				// any return to the reported level restarts the count, so only a stable change passes
				if (hf_raw[gi] != hf_fault_reg[gi]) begin
					if (cnt_reg[gi] >= settle_target[gi] - 12'h001) begin
						hf_fault_next[gi] = hf_raw[gi];
					end else begin
						cnt_next[gi] = cnt_reg[gi] + 12'h001;
					end
				end
			end

			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					cnt_reg[gi] <= cwtr_pkg::SETTLE_CNT_ZERO;
					hf_fault_reg[gi] <= 1'b0;
				end else begin
					cnt_reg[gi] <= cnt_next[gi];
					hf_fault_reg[gi] <= hf_fault_next[gi];
				end
			end
		end
	endgenerate

	always_comb begin
		lf_fault_next[0] = lf_sample_mv < mv_reg.lf_under;
		lf_fault_next[1] = lf_sample_mv > mv_reg.lf_over;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			lf_fault_reg <= 2'h0;
		end else begin
			lf_fault_reg <= lf_fault_next;
		end
	end

	assign faults.hf_under = hf_fault_reg[0];
	assign faults.hf_over = hf_fault_reg[1];
	assign faults.lf_under = lf_fault_reg[0];
	assign faults.lf_over = lf_fault_reg[1];

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	a_hf_under_write: assert property (reg_wr && reg_addr == 8'h50 |=> limits.hf_under == $past(reg_wdata))
		else $error("fast-path low limit did not take write");
	a_hf_over_write: assert property (reg_wr && reg_addr == 8'h51 |=> limits.hf_over == $past(reg_wdata))
		else $error("fast-path high limit did not take write");
	a_lf_under_write: assert property (reg_wr && reg_addr == 8'h52 |=> limits.lf_under == $past(reg_wdata))
		else $error("slow-path low limit did not take write");
	a_lf_over_write: assert property (reg_wr && reg_addr == 8'h53 ##1 !reg_wr [*2]
		|-> limits.lf_over == $past(reg_wdata, 2))
		else $error("slow-path high limit lost its write");
	a_hf_under_read: assert property (reg_rd && reg_addr == 8'h50
		|=> reg_rvalid && reg_rdata == $past(limits.hf_under))
		else $error("fast-path low limit read mismatch");
	a_hf_over_read: assert property (reg_rd && reg_addr == 8'h51
		|=> reg_rvalid && reg_rdata == $past(limits.hf_over))
		else $error("fast-path high limit read mismatch");
	a_lf_under_read: assert property (reg_rd && reg_addr == 8'h52
		|=> reg_rvalid && reg_rdata == $past(limits.lf_under))
		else $error("slow-path low limit read mismatch");
	a_lf_over_read: assert property (reg_rd && reg_addr == 8'h53
		|=> reg_rvalid && reg_rdata == $past(limits.lf_over))
		else $error("slow-path high limit read mismatch");
	a_hf_under_hold: assert property (!(reg_wr && reg_addr == 8'h50) |=> $stable(limits.hf_under))
		else $error("fast-path low limit changed without write");
	a_hf_over_hold: assert property (!(reg_wr && reg_addr == 8'h51) |=> $stable(limits.hf_over))
		else $error("fast-path high limit changed without write");
	a_lf_under_hold: assert property (!(reg_wr && reg_addr == 8'h52) |=> $stable(limits.lf_under))
		else $error("slow-path low limit changed without write");
	a_lf_over_hold: assert property (!(reg_wr && reg_addr == 8'h53) |=> $stable(limits.lf_over))
		else $error("slow-path high limit changed without write");
	a_unity_scale_mv: assert property (!range_scale_select
		|=> limits_mv.hf_under == 13'(13'd200 + 13'd5 * $past(limits.hf_under)))
		else $error("unity scale conversion wrong");
	a_unity_scale_over: assert property (!range_scale_select
		|=> limits_mv.hf_over == 13'(13'd200 + 13'd5 * $past(limits.hf_over)))
		else $error("unity scale high limit conversion wrong");
	a_four_scale_mv: assert property (range_scale_select
		|=> limits_mv.lf_over == 13'(13'd800 + 13'd20 * $past(limits.lf_over)))
		else $error("fourfold scale conversion wrong");
	a_four_scale_under: assert property (range_scale_select
		|=> limits_mv.hf_under == 13'(13'd800 + 13'd20 * $past(limits.hf_under)))
		else $error("fourfold scale low limit conversion wrong");
	a_hf_settle_hold: assert property ($rose(faults.hf_over)
		|-> $past(hf_raw[1], 1) && $past(hf_raw[1], 2) && $past(hf_raw[1], 3))
		else $error("fast-path overvoltage reported before settling");
	a_hf_under_settle: assert property ($rose(faults.hf_under)
		|-> $past(hf_raw[0], 1) && $past(hf_raw[0], 2) && $past(hf_raw[0], 3))
		else $error("fast-path undervoltage reported before settling");
	a_hf_clear_hold: assert property ($fell(faults.hf_over)
		|-> !$past(hf_raw[1], 1) && !$past(hf_raw[1], 2) && !$past(hf_raw[1], 3))
		else $error("fast-path overvoltage cleared before settling");
	a_hf_settle_count: assert property ($changed(faults.hf_under)
		|-> $past(cnt_reg[0]) == $past(settle_target[0]) - 12'h001)
		else $error("fast-path undervoltage settle count wrong");
	a_lf_compare: assert property (lf_sample_mv > limits_mv.lf_over ##1 $stable(limits_mv.lf_over)
		|-> faults.lf_over)
		else $error("slow-path overvoltage not flagged");
	a_lf_under_compare: assert property (lf_sample_mv < limits_mv.lf_under |=> faults.lf_under)
		else $error("slow-path undervoltage not flagged");
	a_lf_over_clear: assert property (lf_sample_mv <= limits_mv.lf_over |=> !faults.lf_over)
		else $error("slow-path overvoltage flagged inside limit");

endmodule : cwtr_regs

// ---- tb/cwtr_host.sv ----
`timescale 1ns/1ps
module cwtr_host (
	input wire logic clock, // system clock
	output logic [7:0] reg_addr, // register address
	output logic reg_wr, // write strobe
	output logic [7:0] reg_wdata, // write data
	output logic reg_rd, // read strobe
	input wire logic [7:0] reg_rdata, // read data
	input wire logic reg_rvalid // read data valid
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	// released lines show the inverse so a stale value is never mistaken for a live one
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		// read data stands for one cycle only, so take it before releasing the strobe
		d = reg_rdata;
		v = reg_rvalid;
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask : rd
endmodule : cwtr_host

// ---- tb/cwtr_regs_tb.sv ----
`timescale 1ns/1ps
module cwtr_regs_tb;
	logic clock, resetn, scale, vld;
	logic [3:0] hi_set, lo_set;
	logic [12:0] hf_mv, lf_mv;
	logic [7:0] addr, wdata, rdata, rdv;
	logic wr, rd, rvalid;
	cwtr_pkg::cwtr_limits_t limits;
	cwtr_pkg::cwtr_limits_mv_t limits_mv;
	cwtr_pkg::cwtr_faults_t faults;
	int err_count = 0, n_checks = 0, cycles = 0;
	cwtr_regs u_cwtr_regs (.clock(clock), .resetn(resetn), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
		.reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid), .range_scale_select(scale),
		.high_fault_settle_time(hi_set), .low_fault_settle_time(lo_set), .hf_sample_mv(hf_mv),
		.lf_sample_mv(lf_mv), .limits(limits), .limits_mv(limits_mv), .faults(faults));
	cwtr_host u_cwtr_host (.clock(clock), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
		.reg_rdata(rdata), .reg_rvalid(rvalid));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// tests need under a hundred cycles; the ceiling only catches a hang
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			end_of_test();
		end
	end
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		u_cwtr_host.rd(a, rdv, vld);
		chk({12'h000, vld}, 13'h0001);
		chk({5'h00, rdv}, {5'h00, exp});
	endtask : rchk
	task automatic ticks(input int n);
		repeat (n) @(negedge clock);
	endtask : ticks
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		chk({5'h00, limits.hf_under}, 13'h0000);
		chk({5'h00, limits.hf_over}, 13'h00ff);
		chk(limits_mv.lf_under, 13'd200);
		chk(limits_mv.lf_over, 13'd1475);
		chk({9'h000, faults}, 13'h0000);
		rchk(8'h50, 8'h00);
		rchk(8'h51, 8'hff);
		rchk(8'h52, 8'h00);
		rchk(8'h53, 8'hff);
	endtask : t_reset
	task automatic t_rw();
		u_cwtr_host.wr(8'h50, 8'h5a);
		u_cwtr_host.wr(8'h51, 8'ha5);
		u_cwtr_host.wr(8'h52, 8'h01);
		u_cwtr_host.wr(8'h54, 8'h77);
		u_cwtr_host.wr(8'h53, 8'hfe);
		rchk(8'h50, 8'h5a);
		rchk(8'h51, 8'ha5);
		rchk(8'h52, 8'h01);
		rchk(8'h53, 8'hfe);
		rchk(8'h54, 8'h00);
		chk({5'h00, limits.lf_over}, 13'h00fe);
	endtask : t_rw
	task automatic t_scale();
		u_cwtr_host.wr(8'h50, 8'h10);
		u_cwtr_host.wr(8'h51, 8'hff);
		ticks(1);
		chk(limits_mv.hf_under, 13'd280);
		chk(limits_mv.hf_over, 13'd1475);
		scale = 1'b1;
		ticks(2);
		chk(limits_mv.hf_under, 13'd1120);
		chk(limits_mv.hf_over, 13'd5900);
		chk({5'h00, limits.hf_under}, 13'h0010);
		scale = 1'b0;
		ticks(2);
		chk(limits_mv.hf_under, 13'd280);
	endtask : t_scale
	task automatic t_slow();
		lf_mv = 13'd204;
		ticks(1);
		chk({12'h000, faults.lf_under}, 13'h0001);
		lf_mv = 13'd205;
		ticks(1);
		chk({12'h000, faults.lf_under}, 13'h0000);
		lf_mv = 13'd1471;
		ticks(1);
		chk({12'h000, faults.lf_over}, 13'h0001);
		lf_mv = 13'd1470;
		ticks(1);
		chk({12'h000, faults.lf_over}, 13'h0000);
	endtask : t_slow
	task automatic t_fast();
		hf_mv = 13'd1476;
		ticks(2);
		chk({12'h000, faults.hf_over}, 13'h0000);
		ticks(1);
		chk({12'h000, faults.hf_over}, 13'h0001);
		hf_mv = 13'd279;
		ticks(3);
		chk({12'h000, faults.hf_over}, 13'h0000);
		ticks(1);
		chk({12'h000, faults.hf_under}, 13'h0000);
		ticks(1);
		chk({12'h000, faults.hf_under}, 13'h0001);
	endtask : t_fast
	initial begin
		resetn = 1'b0;
		scale = 1'b0;
		hi_set = 4'h0;
		lo_set = 4'h1;
		hf_mv = 13'd800;
		lf_mv = 13'd800;
		repeat (6) @(posedge clock);
		@(negedge clock);
		resetn = 1'b1;
		ticks(1);
		t_reset();
		t_rw();
		t_scale();
		t_slow();
		t_fast();
		end_of_test();
	end
endmodule : cwtr_regs_tb
